// ### csp_device.sv
/*
 * csp_device: codec end of the audio serial port with its four registers.
 * assumes: pins are synchronous to clk; the clock tree gives fs_tick at the
 * higher of the adc and dac rates; samples are msb-justified in 32 bits.
 */
`timescale 1ns/1ps

// Overview of operation
// - I2S, LJF, RJF, DSP and TDM framing
// - msb first, width 16/20/24/32 selectable
// - word and bit clock each master/slave
// - word clock marks frame, pulse or square
// - word clock at higher converter rate
// - master bit clock rate from divider
// - first data bit delayed by offset, except in RJF
// - invert bit clock edge in every format
// - optional hi-Z data outside valid bits
// - powered-down master puts pins hi-Z
// - generated clocks run only with converter
// - option keeps generated clocks running without converter
module csp_device
	import csp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// register port
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// power and rate
	input  wire logic        port_pwr,
	input  wire logic        adc_pwr,
	input  wire logic        dac_pwr,
	input  wire logic        fs_tick,
	// converter samples
	input  wire logic [31:0] adc_left,
	input  wire logic [31:0] adc_right,
	output logic      [31:0] dac_left,
	output logic      [31:0] dac_right,
	output logic             dac_valid,
	// serial bus
	csp_if.device            bus
);

	// registers
	logic [7:0]  fmt_r;        // format control
	logic [7:0]  offs_r;       // data start offset in bit clocks
	logic [7:0]  pol_r;        // bit clock polarity
	logic [7:0]  div_r;        // bit clock divider
	// clock generation
	logic [7:0]  dcnt_r;       // divider counter
	logic        bclk_r;       // generated bit clock
	logic        wclk_r;       // generated word clock
	logic        fs_pend_r;    // frame request waiting for a launch edge
	logic [7:0]  flen_r;       // measured frame length in bit clocks
	// frame engine
	logic        bprev_r;      // bit clock level one cycle back
	logic        wprev_r;      // word clock level at the last launch
	logic [7:0]  pos_r;        // bit position inside frame or half
	logic [7:0]  hlen_r;       // measured half-frame length
	logic        rhalf_r;      // current half is the right word
	csp_slot_s   slot_r;       // slot of the bit on the line now
	logic [31:0] rx_sh_r;      // incoming word
	logic        dout_r;
	logic        dout_oe_r;
	logic        bclk_oe_r;
	logic        wclk_oe_r;

	// decoded controls
	logic [1:0]  mode;
	logic [5:0]  wbits;
	logic        bmst;
	logic        wmst;
	logic        lvl_launch;
	logic        run;
	logic        tc;
	logic        bclk_lvl;
	logic        wclk_lvl;
	logic        launch;
	logic        capture;
	logic        wtick;
	logic        pulse;
	logic        fedge;
	logic [7:0]  pos_nxt;
	logic        rhalf_nxt;
	csp_slot_s   slot_nxt;
	logic [31:0] rx_word;

	assign mode       = fmt_r[CSP_F_MODE_LSB +: 2];
	assign wbits      = csp_wbits(fmt_r[CSP_F_WIDTH_LSB +: 2]);
	assign bmst       = fmt_r[CSP_F_BCLK_MST];
	assign wmst       = fmt_r[CSP_F_WCLK_MST];
	assign pulse      = (mode == CSP_MODE_DSP);
	// launch on the falling edge by default, rising when inverted
	assign lvl_launch = pol_r[CSP_P_INVERT];
	// generated clocks need a powered port and a live converter or the keep bit
	assign run        = port_pwr & (adc_pwr | dac_pwr | fmt_r[CSP_F_KEEP_ON]);
	// a divider of zero behaves as one
	assign tc         = run & bmst & (dcnt_r + 8'h01 >= ((div_r == 8'h00) ? 8'h01 : div_r));
	// slave clocks come only from the pins
	assign bclk_lvl   = bmst ? bclk_r : bus.bclk;
	assign wclk_lvl   = wmst ? wclk_r : bus.wclk;
	assign launch     = (bclk_lvl != bprev_r) & (bclk_lvl == lvl_launch);
	assign capture    = (bclk_lvl != bprev_r) & (bclk_lvl != lvl_launch);
	// master word clock moves together with the bit clock launch edge
	assign wtick      = bmst ? (tc & (bclk_r != lvl_launch)) : launch;

	// register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fmt_r  <= CSP_RST_FORMAT;
			offs_r <= CSP_RST_OFFSET;
			pol_r  <= CSP_RST_POL;
			div_r  <= CSP_RST_DIVIDER;
		end else if (reg_wr) begin
			if (reg_addr == CSP_REG_FORMAT) begin
				fmt_r <= reg_wdata;
			end else if (reg_addr == CSP_REG_OFFSET) begin
				offs_r <= reg_wdata;
			end else if (reg_addr == CSP_REG_POL) begin
				pol_r <= reg_wdata;
			end else if (reg_addr == CSP_REG_DIVIDER) begin
				div_r <= reg_wdata;
			end
		end
	end

	// register read data, registered; unmapped addresses read zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == CSP_REG_FORMAT) begin
			reg_rdata <= fmt_r;
		end else if (reg_addr == CSP_REG_OFFSET) begin
			reg_rdata <= offs_r;
		end else if (reg_addr == CSP_REG_POL) begin
			reg_rdata <= pol_r;
		end else if (reg_addr == CSP_REG_DIVIDER) begin
			reg_rdata <= div_r;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// bit clock divider; the clock freezes where it is when it stops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dcnt_r <= 8'h00;
			bclk_r <= 1'b0;
		end else if (tc) begin
			dcnt_r <= 8'h00;
			bclk_r <= ~bclk_r;
		end else if (run & bmst) begin
			dcnt_r <= dcnt_r + 8'h01;
		end
	end

	// frame requests from the clock tree; a new request beats the clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fs_pend_r <= 1'b0;
		end else if (fs_tick & run) begin
			fs_pend_r <= 1'b1;
		end else if (wtick) begin
			fs_pend_r <= 1'b0;
		end
	end

	// master word clock: pulse of one bit clock or square of half a frame
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wclk_r <= 1'b0;
			flen_r <= 8'h00;
		end else if (wmst & wtick) begin
			if (fs_pend_r) begin
				// a square frame spans both halves, so add the finished left half
				flen_r <= pos_r + 8'h01 + ((pulse || !rhalf_r) ? 8'h00 : hlen_r);
				wclk_r <= pulse | (mode != CSP_MODE_I2S);
			end else if (pulse) begin
				wclk_r <= 1'b0;
			end else if (pos_r + 8'h01 == {1'b0, flen_r[7:1]} && !rhalf_r) begin
				wclk_r <= ~wclk_r;
			end
		end
	end

	// next position, counted from each frame or half-frame marker
	always_comb begin
		fedge     = pulse ? (wclk_lvl & ~wprev_r) : (wclk_lvl != wprev_r);
		pos_nxt   = fedge ? 8'h00 : ((pos_r == 8'hFF) ? pos_r : pos_r + 8'h01);
		rhalf_nxt = pulse ? 1'b0 : (wclk_lvl == (mode == CSP_MODE_I2S));
		slot_nxt  = csp_slot(mode, wbits, offs_r, hlen_r, rhalf_nxt, pos_nxt);
	end

	// launch side: move position and put the next bit on the line
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bprev_r   <= 1'b0;
			wprev_r   <= 1'b0;
			pos_r     <= 8'h00;
			hlen_r    <= 8'h00;
			rhalf_r   <= 1'b0;
			slot_r    <= '0;
			dout_r    <= 1'b0;
			dout_oe_r <= 1'b0;
		end else begin
			bprev_r <= bclk_lvl;
			if (!port_pwr) begin
				dout_oe_r <= 1'b0;
			end else if (launch) begin
				wprev_r <= wclk_lvl;
				pos_r   <= pos_nxt;
				rhalf_r <= rhalf_nxt;
				slot_r  <= slot_nxt;
				if (fedge && !pulse)
					hlen_r <= pos_r + 8'h01;
				// msb first: word bit idx 0 is sample bit 31
				dout_r    <= slot_nxt.valid &
					(slot_nxt.right ? adc_right[5'(6'h1F - slot_nxt.idx)] : adc_left[5'(6'h1F - slot_nxt.idx)]);
				dout_oe_r <= slot_nxt.valid | ~fmt_r[CSP_F_TRISTATE];
			end
		end
	end

	// assembled word, msb-justified in 32 bits
	assign rx_word = {rx_sh_r[30:0], bus.din} << (6'h20 - wbits);

	// capture side: shift in host data, hand over each complete word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_sh_r   <= 32'h0000_0000;
			dac_left  <= 32'h0000_0000;
			dac_right <= 32'h0000_0000;
			dac_valid <= 1'b0;
		end else begin
			dac_valid <= 1'b0;
			if (capture && slot_r.valid) begin
				rx_sh_r <= {rx_sh_r[30:0], bus.din};
				if (slot_r.idx == wbits - 6'h01) begin
					if (slot_r.right) begin
						dac_right <= rx_word;
						dac_valid <= 1'b1;
					end else begin
						dac_left <= rx_word;
					end
				end
			end
		end
	end

	// pin enables: drive only what is mastered here, nothing when powered down
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bclk_oe_r <= 1'b0;
			wclk_oe_r <= 1'b0;
		end else begin
			bclk_oe_r <= port_pwr & bmst;
			wclk_oe_r <= port_pwr & wmst;
		end
	end

	assign bus.dev_bclk_o  = bclk_r;
	assign bus.dev_bclk_oe = bclk_oe_r;
	assign bus.dev_wclk_o  = wclk_r;
	assign bus.dev_wclk_oe = wclk_oe_r;
	assign bus.dev_dout_o  = dout_r;
	assign bus.dev_dout_oe = dout_oe_r;

endmodule

// ### csp_pkg.sv
/*
 * csp_pkg: shared constants, field layout and slot decoding for the
 * codec audio serial port (device end and host end).
 * assumes: both ends include this package through a wildcard import.
 */
package csp_pkg;

	// device register offsets (8-bit register port)
	localparam logic [7:0] CSP_REG_FORMAT  = 8'h1B;
	localparam logic [7:0] CSP_REG_OFFSET  = 8'h1C;
	localparam logic [7:0] CSP_REG_POL     = 8'h1D;
	localparam logic [7:0] CSP_REG_DIVIDER = 8'h1E;

	// format register fields
	localparam int CSP_F_MODE_LSB  = 6;  // [7:6] framing mode
	localparam int CSP_F_WIDTH_LSB = 4;  // [5:4] word width select
	localparam int CSP_F_BCLK_MST  = 3;  // bit clock generated here
	localparam int CSP_F_WCLK_MST  = 2;  // word clock generated here
	localparam int CSP_F_KEEP_ON   = 1;  // keep generated clocks running
	localparam int CSP_F_TRISTATE  = 0;  // hi-Z data outside valid slots
	localparam int CSP_P_INVERT    = 3;  // polarity register: invert bit clock

	// reset values
	localparam logic [7:0] CSP_RST_FORMAT  = 8'h00;
	localparam logic [7:0] CSP_RST_OFFSET  = 8'h00;
	localparam logic [7:0] CSP_RST_POL     = 8'h00;
	localparam logic [7:0] CSP_RST_DIVIDER = 8'h01;
	localparam logic [7:0] CSP_RST_FRAME   = 8'h40;

	// framing modes; tdm and pcm are dsp framing with offset and hi-Z
	localparam logic [1:0] CSP_MODE_I2S = 2'h0;
	localparam logic [1:0] CSP_MODE_DSP = 2'h1;
	localparam logic [1:0] CSP_MODE_RJF = 2'h2;
	localparam logic [1:0] CSP_MODE_LJF = 2'h3;

	// host apb map (byte addresses)
	localparam logic [7:0] CSP_H_CFG    = 8'h00;
	localparam logic [7:0] CSP_H_OFFSET = 8'h04;
	localparam logic [7:0] CSP_H_CLK    = 8'h08;
	localparam logic [7:0] CSP_H_TXL    = 8'h0C;
	localparam logic [7:0] CSP_H_TXR    = 8'h10;
	localparam logic [7:0] CSP_H_RXL    = 8'h14;
	localparam logic [7:0] CSP_H_RXR    = 8'h18;
	localparam logic [7:0] CSP_H_STAT   = 8'h1C;
	localparam int CSP_H_CLK_FRAME_LSB  = 8;   // [15:8] bit clocks per frame
	localparam int CSP_H_CLK_INV        = 16;  // invert bit clock

	// one decoded bit position inside a frame
	typedef struct packed {
		logic       valid;  // position carries a data bit
		logic       right;  // right channel word
		logic [5:0] idx;    // bit index inside the word, 0 = msb
	} csp_slot_s;

	// width select to bits: 16, 20, 24, 32
	function automatic logic [5:0] csp_wbits(input logic [1:0] sel);
		case (sel)
			2'h0: csp_wbits = 6'h10;
			2'h1: csp_wbits = 6'h14;
			2'h2: csp_wbits = 6'h18;
			default: csp_wbits = 6'h20;
		endcase
	endfunction

	// decode which word bit, if any, sits at position pos
	function automatic csp_slot_s csp_slot(input logic [1:0] mode, input logic [5:0] wb, input logic [7:0] offs,
			input logic [7:0] half, input logic rhalf, input logic [7:0] pos);
		logic [8:0] start;
		logic [8:0] k;
		csp_slot_s  s;
		s = '0;
		if (mode == CSP_MODE_DSP) begin
			// both words back to back after the offset
			start = {1'b0, offs};
			k     = {1'b0, pos} - start;
			if ({1'b0, pos} >= start && k < {2'h0, wb, 1'b0}) begin
				s.valid = 1'b1;
				s.right = (k >= {3'h0, wb});
				s.idx   = s.right ? 6'(k - {3'h0, wb}) : k[5:0];
			end
		end else begin
			// each word sits in its own word-clock half
			if (mode == CSP_MODE_RJF)
				start = {1'b0, half} - {3'h0, wb};
			else if (mode == CSP_MODE_I2S)
				start = {1'b0, offs} + 9'h001;
			else
				start = {1'b0, offs};
			k = {1'b0, pos} - start;
			if ({1'b0, pos} >= start && k < {3'h0, wb}) begin
				s.valid = 1'b1;
				s.right = rhalf;
				s.idx   = k[5:0];
			end
		end
		return s;
	endfunction

endpackage

// ### csp_if.sv
/*
 * csp_if: the audio serial bus between the codec device and the host.
 * assumes: each end drives its own output and enable; undriven lines read low.
 */
`timescale 1ns/1ps
interface csp_if;
	// bit clock
	logic dev_bclk_o;
	logic dev_bclk_oe;
	logic host_bclk_o;
	logic host_bclk_oe;
	// word clock
	logic dev_wclk_o;
	logic dev_wclk_oe;
	logic host_wclk_o;
	logic host_wclk_oe;
	// data, device to host and host to device
	logic dev_dout_o;
	logic dev_dout_oe;
	logic host_din_o;
	logic host_din_oe;
	// resolved line levels
	logic bclk;
	logic wclk;
	logic dout;
	logic din;

	// an undriven line is taken as pulled low
	assign bclk = dev_bclk_oe ? dev_bclk_o : (host_bclk_oe ? host_bclk_o : 1'b0);
	assign wclk = dev_wclk_oe ? dev_wclk_o : (host_wclk_oe ? host_wclk_o : 1'b0);
	assign dout = dev_dout_oe ? dev_dout_o : 1'b0;
	assign din  = host_din_oe ? host_din_o : 1'b0;

	modport device (output dev_bclk_o, dev_bclk_oe, dev_wclk_o, dev_wclk_oe, dev_dout_o, dev_dout_oe,
		input bclk, wclk, din);
	modport host (output host_bclk_o, host_bclk_oe, host_wclk_o, host_wclk_oe, host_din_o, host_din_oe,
		input bclk, wclk, dout);
endinterface

// ### csp_host.sv
/*
 * csp_host: host processor end of the audio serial port, an apb slave.
 * assumes: pins are synchronous to clk; software mirrors the device setup.
 */
`timescale 1ns/1ps
module csp_host
	import csp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial bus
	csp_if.host              bus
);

	logic [7:0]  cfg_r;      // format, same layout as device format register
	logic [7:0]  offs_r;     // data start offset
	logic [16:0] clk_r;      // divider, frame length, invert
	logic [31:0] txl_r;
	logic [31:0] txr_r;
	logic [31:0] rxl_r;
	logic [31:0] rxr_r;
	logic        rx_new_r;   // sticky: right word received
	logic [7:0]  dcnt_r;
	logic        bclk_r;
	logic        wclk_r;
	logic        bprev_r;
	logic        wprev_r;
	logic [7:0]  pos_r;
	logic [7:0]  hlen_r;
	logic        rhalf_r;
	csp_slot_s   slot_r;
	logic [31:0] rx_sh_r;
	logic        din_r;
	logic        din_oe_r;

	logic        wr_acc;
	logic        sel_ok;
	logic [1:0]  mode;
	logic [5:0]  wbits;
	logic        bmst;
	logic        wmst;
	logic        lvl_launch;
	logic        pulse;
	logic        tc;
	logic        bclk_lvl;
	logic        wclk_lvl;
	logic        launch;
	logic        capture;
	logic        wtick;
	logic        fedge;
	logic        rx_done;
	logic [7:0]  flen;
	logic [7:0]  pos_nxt;
	logic        rhalf_nxt;
	csp_slot_s   slot_nxt;

	assign mode       = cfg_r[CSP_F_MODE_LSB +: 2];
	assign wbits      = csp_wbits(cfg_r[CSP_F_WIDTH_LSB +: 2]);
	assign bmst       = cfg_r[CSP_F_BCLK_MST];
	assign wmst       = cfg_r[CSP_F_WCLK_MST];
	assign pulse      = (mode == CSP_MODE_DSP);
	assign lvl_launch = clk_r[CSP_H_CLK_INV];
	assign flen       = clk_r[CSP_H_CLK_FRAME_LSB +: 8];
	assign tc         = bmst & (dcnt_r + 8'h01 >= ((clk_r[7:0] == 8'h00) ? 8'h01 : clk_r[7:0]));
	assign bclk_lvl   = bmst ? bclk_r : bus.bclk;
	assign wclk_lvl   = wmst ? wclk_r : bus.wclk;
	assign launch     = (bclk_lvl != bprev_r) & (bclk_lvl == lvl_launch);
	assign capture    = (bclk_lvl != bprev_r) & (bclk_lvl != lvl_launch);
	assign wtick      = bmst ? (tc & (bclk_r != lvl_launch)) : launch;
	assign wr_acc     = psel & penable & pwrite;
	assign rx_done    = capture & slot_r.valid & slot_r.right & (slot_r.idx == wbits - 6'h01);

	// address check; anything off the map answers with an error
	always_comb begin
		if (paddr == CSP_H_CFG || paddr == CSP_H_OFFSET || paddr == CSP_H_CLK || paddr == CSP_H_TXL)
			sel_ok = 1'b1;
		else if (paddr == CSP_H_TXR || paddr == CSP_H_RXL || paddr == CSP_H_RXR || paddr == CSP_H_STAT)
			sel_ok = 1'b1;
		else
			sel_ok = 1'b0;
	end

	// apb writes; received words are read-only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_r  <= CSP_RST_FORMAT;
			offs_r <= CSP_RST_OFFSET;
			clk_r  <= {1'b0, CSP_RST_FRAME, CSP_RST_DIVIDER};
			txl_r  <= 32'h0000_0000;
			txr_r  <= 32'h0000_0000;
		end else if (wr_acc) begin
			if (paddr == CSP_H_CFG) begin
				cfg_r <= pwdata[7:0];
			end else if (paddr == CSP_H_OFFSET) begin
				offs_r <= pwdata[7:0];
			end else if (paddr == CSP_H_CLK) begin
				clk_r <= pwdata[16:0];
			end else if (paddr == CSP_H_TXL) begin
				txl_r <= pwdata;
			end else if (paddr == CSP_H_TXR) begin
				txr_r <= pwdata;
			end
		end
	end

	// zero-wait answer: data and ready are set up in the setup cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~sel_ok;
			if (paddr == CSP_H_CFG)
				prdata <= {24'h000000, cfg_r};
			else if (paddr == CSP_H_OFFSET)
				prdata <= {24'h000000, offs_r};
			else if (paddr == CSP_H_CLK)
				prdata <= {15'h0000, clk_r};
			else if (paddr == CSP_H_TXL)
				prdata <= txl_r;
			else if (paddr == CSP_H_TXR)
				prdata <= txr_r;
			else if (paddr == CSP_H_RXL)
				prdata <= rxl_r;
			else if (paddr == CSP_H_RXR)
				prdata <= rxr_r;
			else if (paddr == CSP_H_STAT)
				prdata <= {31'h0000_0000, rx_new_r};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// sticky receive flag, write one to clear; a new word wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rx_new_r <= 1'b0;
		else if (rx_done)
			rx_new_r <= 1'b1;
		else if (wr_acc && paddr == CSP_H_STAT && pwdata[0])
			rx_new_r <= 1'b0;
	end

	// host-mastered clocks: divider and fixed frame length
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dcnt_r <= 8'h00;
			bclk_r <= 1'b0;
			wclk_r <= 1'b0;
		end else begin
			if (tc) begin
				dcnt_r <= 8'h00;
				bclk_r <= ~bclk_r;
			end else if (bmst) begin
				dcnt_r <= dcnt_r + 8'h01;
			end
			if (wmst && wtick) begin
				if (pos_r + 8'h01 >= flen || (!pulse && rhalf_r && pos_r + 8'h01 >= {1'b0, flen[7:1]}))
					wclk_r <= pulse | (mode != CSP_MODE_I2S);
				else if (pulse)
					wclk_r <= 1'b0;
				else if (!rhalf_r && pos_r + 8'h01 == {1'b0, flen[7:1]})
					wclk_r <= ~wclk_r;
			end
		end
	end

	// next position from the frame marker
	always_comb begin
		fedge     = pulse ? (wclk_lvl & ~wprev_r) : (wclk_lvl != wprev_r);
		pos_nxt   = fedge ? 8'h00 : ((pos_r == 8'hFF) ? pos_r : pos_r + 8'h01);
		rhalf_nxt = pulse ? 1'b0 : (wclk_lvl == (mode == CSP_MODE_I2S));
		slot_nxt  = csp_slot(mode, wbits, offs_r, hlen_r, rhalf_nxt, pos_nxt);
	end

	// launch side: host data onto din
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bprev_r  <= 1'b0;
			wprev_r  <= 1'b0;
			pos_r    <= 8'h00;
			hlen_r   <= 8'h00;
			rhalf_r  <= 1'b0;
			slot_r   <= '0;
			din_r    <= 1'b0;
			din_oe_r <= 1'b0;
		end else begin
			bprev_r <= bclk_lvl;
			if (launch) begin
				wprev_r <= wclk_lvl;
				pos_r   <= pos_nxt;
				rhalf_r <= rhalf_nxt;
				slot_r  <= slot_nxt;
				if (fedge && !pulse)
					hlen_r <= pos_r + 8'h01;
				din_r    <= slot_nxt.valid &
					(slot_nxt.right ? txr_r[5'(6'h1F - slot_nxt.idx)] : txl_r[5'(6'h1F - slot_nxt.idx)]);
				din_oe_r <= slot_nxt.valid | ~cfg_r[CSP_F_TRISTATE];
			end
		end
	end

	// capture side: words from the device, msb-justified
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_sh_r <= 32'h0000_0000;
			rxl_r   <= 32'h0000_0000;
			rxr_r   <= 32'h0000_0000;
		end else if (capture && slot_r.valid) begin
			rx_sh_r <= {rx_sh_r[30:0], bus.dout};
			if (slot_r.idx == wbits - 6'h01) begin
				if (slot_r.right)
					rxr_r <= {rx_sh_r[30:0], bus.dout} << (6'h20 - wbits);
				else
					rxl_r <= {rx_sh_r[30:0], bus.dout} << (6'h20 - wbits);
			end
		end
	end

	assign bus.host_bclk_o  = bclk_r;
	assign bus.host_bclk_oe = bmst;
	assign bus.host_wclk_o  = wclk_r;
	assign bus.host_wclk_oe = wmst;
	assign bus.host_din_o   = din_r;
	assign bus.host_din_oe  = din_oe_r;

endmodule

// ### csp_asserts.sv
/* csp_asserts: timing checks on the audio serial lines.
 assumes: sits beside csp_if, sampled on the system clock. */
`timescale 1ns/1ps
module csp_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// enables and line levels
	input wire logic dev_bclk_oe,
	input wire logic host_bclk_oe,
	input wire logic dev_wclk_oe,
	input wire logic host_wclk_oe,
	input wire logic dev_dout_oe,
	input wire logic host_din_oe,
	input wire logic bclk,
	input wire logic wclk,
	input wire logic dout,
	input wire logic din
);
	logic [2:0] bq_r; // last bclk samples
	wire        moved = (bq_r[0] != bclk) || (bq_r[1] != bq_r[0]) || (bq_r[2] != bq_r[1]);
	// edge history: a follower reacts up to two clk after the edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) bq_r <= 3'h0;
		else bq_r <= {bq_r[1:0], bclk};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_one_bclk; !(dev_bclk_oe && host_bclk_oe); endproperty
	a_one_bclk: assert property (p_one_bclk) else $error("bclk driven twice");
	property p_one_wclk; !(dev_wclk_oe && host_wclk_oe); endproperty
	a_one_wclk: assert property (p_one_wclk) else $error("wclk driven twice");
	property p_rst_quiet; $fell(reset) |-> !(dev_bclk_oe || dev_wclk_oe || dev_dout_oe); endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pins driven at reset");
	property p_dout_edge; dev_dout_oe && $past(dev_dout_oe) && $changed(dout) |-> moved; endproperty
	a_dout_edge: assert property (p_dout_edge) else $error("dout moved off edge");
	property p_wclk_edge; dev_wclk_oe && $past(dev_wclk_oe) && $changed(wclk) |-> moved; endproperty
	a_wclk_edge: assert property (p_wclk_edge) else $error("wclk moved off edge");
	property p_din_edge; host_din_oe && $past(host_din_oe) && $changed(din) |-> moved; endproperty
	a_din_edge: assert property (p_din_edge) else $error("din moved off edge");
	property p_pwr_off; $fell(dev_bclk_oe) |-> !dev_wclk_oe ##1 !dev_dout_oe; endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("pins left driven");
	property p_dout_clk; dev_dout_oe |-> dev_bclk_oe || host_bclk_oe; endproperty
	a_dout_clk: assert property (p_dout_clk) else $error("dout without clock");
	c_dout: cover property (dev_dout_oe && $changed(dout));
	c_din: cover property (host_din_oe && $changed(din));
	c_off: cover property ($fell(dev_bclk_oe));
endmodule

// ### codec_audio_serial_port_tb_top.sv
/* tb: device and host ends joined by csp_if, host driven over apb.
 assumes: package, interface, both ends and checker compiled before. */
`timescale 1ns/1ps
module codec_audio_serial_port_tb_top;
	import csp_pkg::*;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, e;
	logic        reg_wr, port_pwr, adc_pwr, dac_pwr, fs_tick, dac_valid;
	logic [7:0]  paddr, reg_addr, reg_wdata, reg_rdata, f;
	logic [31:0] pwdata, prdata, adc_left, adc_right, dac_left, dac_right, v, tx, sw, mask;
	int          mismatches = 0, n_tests = 0, cyc = 0, n;
	csp_if csp_if_i ();
	csp_device csp_device_i (.*, .bus(csp_if_i));
	csp_host csp_host_i (.*, .bus(csp_if_i));
	csp_asserts csp_asserts_i (.clk(clk), .reset(reset), .dev_bclk_oe(csp_if_i.dev_bclk_oe),
		.host_bclk_oe(csp_if_i.host_bclk_oe), .dev_wclk_oe(csp_if_i.dev_wclk_oe),
		.host_wclk_oe(csp_if_i.host_wclk_oe), .dev_dout_oe(csp_if_i.dev_dout_oe),
		.host_din_oe(csp_if_i.host_din_oe), .bclk(csp_if_i.bclk), .wclk(csp_if_i.wclk),
		.dout(csp_if_i.dout), .din(csp_if_i.din));
	// 10 MHz clock
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// frame tick every 200 clk (100 bit clocks), plus hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fs_tick <= (cyc % 200 == 0);
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", nm, x, s);
		end
	endtask
	// apb transfer; read data and error taken at the rising edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	// one idle edge after each write keeps reg_wr from being set twice at once
	task automatic dw(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk) reg_wr <= 0;
		@(posedge clk);
	endtask
	task automatic dr(input logic [7:0] a);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		v = {24'h0, reg_rdata};
	endtask
	// bclk changes seen over eight clk
	task automatic edges();
		logic b;
		@(negedge clk) b = csp_if_i.bclk;
		n = 0;
		repeat (8) begin
			@(negedge clk) n += int'(csp_if_i.bclk !== b);
			b = csp_if_i.bclk;
		end
		@(posedge clk);
	endtask
	task automatic results();
		if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{reset, psel, penable, pwrite, reg_wr, paddr, pwdata, reg_addr, reg_wdata} = '0;
		reset = 1;
		{port_pwr, adc_pwr, dac_pwr} = 3'h7;
		{adc_left, adc_right} = '0;
		repeat (10) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		dr(CSP_REG_DIVIDER); chk("div", v, 32'h01);
		dr(8'h1F); chk("unmapped", v, 32'h00);
		apb(0, CSP_H_CLK, 0); chk("hclk", v, 32'h0000_4001);
		apb(0, 8'h20, 0); chk("slverr", {31'h0, e}, 32'h1);
		// every framing mode, width follows mode, offset and invert vary
		for (int m = 0; m < 4; m++) begin
			tx = 32'h8C3A_5E71 + m;
			sw = {tx[15:0], tx[31:16]};
			mask = ~(32'hFFFF_FFFF >> ((m == 3) ? 32 : 16 + 4 * m));
			adc_left <= ~tx;
			adc_right <= sw;
			f = {2'(m), 2'(m), 3'h7, m == 1};
			dw(CSP_REG_FORMAT, f);
			dw(CSP_REG_OFFSET, 8'(m));
			dw(CSP_REG_POL, {4'h0, m[0], 3'h0});
			dr(CSP_REG_POL); chk("pol", v, {28'h0, m[0], 3'h0});
			apb(1, CSP_H_CFG, {24'h0, f & 8'hF3});
			apb(1, CSP_H_OFFSET, 32'(m));
			apb(1, CSP_H_CLK, {15'h0, m[0], 16'h4001});
			apb(1, CSP_H_TXL, tx);
			apb(1, CSP_H_TXR, sw);
			repeat (1400) @(posedge clk);
			chk("dac_left", dac_left, tx & mask);
			chk("dac_right", dac_right, sw & mask);
			apb(0, CSP_H_STAT, 0); chk("stat", v & 32'h1, 32'h1);
			apb(1, CSP_H_STAT, 32'h1);
			if (m == 3) begin
				apb(0, CSP_H_RXL, 0); chk("rxl", v, ~tx);
				apb(0, CSP_H_RXR, 0); chk("rxr", v, sw);
			end
		end
		// converters off: clocks kept, then stopped, then port off
		adc_pwr <= 0;
		dac_pwr <= 0;
		repeat (400) @(posedge clk);
		edges(); chk("keep", 32'(n), 32'h8);
		dw(CSP_REG_FORMAT, f & 8'hFD);
		repeat (400) @(posedge clk);
		edges(); chk("stop", 32'(n), 32'h0);
		port_pwr <= 0;
		repeat (3) @(posedge clk);
		chk("hiz", {csp_if_i.dev_bclk_oe, csp_if_i.dev_wclk_oe, csp_if_i.dev_dout_oe}, 32'h0);
		results();
	end
endmodule
